// [src/dscp_pkg.sv]
// Shared constants and enumerations of the converter's serial control port.
// Assumes one system clock domain; every pin is synchronised before use.
package dscp_pkg;

   // ----------------------------------------------------------------
   // Target address and register map
   // ----------------------------------------------------------------
   localparam logic [4:0] DSCP_ADDR_UPPER = 5'h13;
   localparam logic [6:0] DSCP_IDX_LO = 7'h40;
   localparam logic [6:0] DSCP_IDX_HI = 7'h4f;
   localparam int DSCP_REG_COUNT = 16;

   // ----------------------------------------------------------------
   // Framing and timing counts
   // ----------------------------------------------------------------
   localparam logic [4:0] DSCP_SPI_WORD_BITS = 5'h10;
   localparam logic [4:0] DSCP_SPI_BYTE_BITS = 5'h08;
   localparam logic [3:0] DSCP_I2C_BYTE_BITS = 4'h8;
   localparam logic [1:0] DSCP_BOOT_WAIT = 2'h2;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DSCP_MODE_PAR = 2'b00,
      DSCP_MODE_TWO = 2'b01,
      DSCP_MODE_THREE = 2'b10
   } dscp_mode_type;

   typedef enum logic [2:0] {
      DSCP_ST_IDLE = 3'b000,
      DSCP_ST_ADDR = 3'b001,
      DSCP_ST_INDEX = 3'b010,
      DSCP_ST_WDATA = 3'b011,
      DSCP_ST_ACK = 3'b100,
      DSCP_ST_RDATA = 3'b101,
      DSCP_ST_RACK = 3'b110
   } dscp_i2c_type;

endpackage

// [src/dscp_sync.sv]
// Two-flop synchroniser for a group of unrelated level inputs.
// Assumes each bit is a slow level or a clock well below the sampling rate.
`timescale 1ns/1ps
module dscp_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } dscp_sync_type;

   dscp_sync_type q, d;

   if (WIDTH < 1) begin : g_bad_width
      $error("dscp_sync needs at least one bit");
   end

   always_comb begin
      d.meta = async_in;
      d.stable = q.meta;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stable;

endmodule

// [src/dscp_top.sv]
// Serial control port: strap-selected three-wire writer or two-wire target.
// Assumes straps and link pins are asynchronous; open-drain data resolved
// outside from sda_oe.
`timescale 1ns/1ps
module dscp_top
   import dscp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Mode strap pad sensing
   input wire logic mode_strap_hi,
   input wire logic mode_strap_lo,
   // Three-wire port
   input wire logic ctrl_serial_din,
   input wire logic ctrl_shift_clock,
   input wire logic ctrl_port_select_n,
   // Two-wire port
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic bus_addr_strap_lo,
   input wire logic bus_addr_strap_hi,
   // Register write side
   output logic cfg_wr_stb,
   output logic [6:0] cfg_wr_index,
   output logic [7:0] cfg_wr_data,
   // Selected mode
   output logic mode_valid,
   output logic mode_two_wire,
   output logic mode_three_wire,
   output logic mode_parallel
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic booted;
      logic [1:0] boot_cnt;
      dscp_mode_type mode;
      logic sclk_p;
      logic sel_p;
      logic scl_p;
      logic sda_p;
      logic [15:0] s_sh;
      logic [4:0] s_cnt;
      logic s_first;
      logic s_pend;
      logic s_bad;
      logic [6:0] s_idx;
      logic [7:0] s_dat;
      dscp_i2c_type st;
      dscp_i2c_type nxt;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [6:0] idx;
      logic oe;
      logic wr_stb;
      logic [6:0] wr_idx;
      logic [7:0] wr_dat;
      logic [DSCP_REG_COUNT-1:0][7:0] regs;
   } dscp_state_type;

   dscp_state_type q, d;
   logic [8:0] sync_v;
   logic strap_hi_s, strap_lo_s, din_s, sclk_s, sel_s;
   logic scl_s, sda_s, adr_hi_s, adr_lo_s;
   logic sclk_rise, sel_rise, scl_rise, scl_fall, i2c_start, i2c_stop;
   logic spi_on, i2c_on, do_wr, addr_match;
   logic [6:0] wi, own_addr;
   logic [7:0] wd;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   dscp_sync #(
      .WIDTH(9)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({mode_strap_hi, mode_strap_lo, ctrl_serial_din,
                 ctrl_shift_clock, ctrl_port_select_n, scl_in, sda_in,
                 bus_addr_strap_hi, bus_addr_strap_lo}),
      .sync_out(sync_v)
   );

   assign {strap_hi_s, strap_lo_s, din_s, sclk_s, sel_s, scl_s, sda_s,
           adr_hi_s, adr_lo_s} = sync_v;

   function automatic logic in_map(input logic [6:0] i);
      in_map = (i >= DSCP_IDX_LO) && (i <= DSCP_IDX_HI);
   endfunction

   function automatic logic [6:0] advance(input logic [6:0] i);
      advance = (i == DSCP_IDX_HI) ? DSCP_IDX_LO : 7'(i + 7'h01);
   endfunction

   // ----------------------------------------------------------------
   // Edge and condition detection
   // ----------------------------------------------------------------
   // Both ports are oversampled on the system clock, so the link timing
   // never has to line up with the audio clocks.
   assign spi_on = q.booted && (q.mode == DSCP_MODE_THREE);
   assign i2c_on = q.booted && (q.mode == DSCP_MODE_TWO);
   assign sclk_rise = sclk_s && !q.sclk_p;
   assign sel_rise = sel_s && !q.sel_p;
   assign scl_rise = scl_s && !q.scl_p;
   assign scl_fall = !scl_s && q.scl_p;
   assign i2c_start = scl_s && q.scl_p && q.sda_p && !sda_s;
   assign i2c_stop = scl_s && q.scl_p && !q.sda_p && sda_s;
   assign own_addr = {DSCP_ADDR_UPPER, adr_hi_s, adr_lo_s};
   assign addr_match = (q.sh[7:1] == own_addr);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      do_wr = 1'b0;
      wi = '0;
      wd = '0;
      d.wr_stb = 1'b0;
      d.sclk_p = sclk_s;
      d.sel_p = sel_s;
      d.scl_p = scl_s;
      d.sda_p = sda_s;

      // Strap is read once, after the synchronisers have settled
      if (!q.booted) begin
         if (q.boot_cnt == DSCP_BOOT_WAIT) begin
            d.booted = 1'b1;
            if (strap_hi_s) begin
               d.mode = DSCP_MODE_THREE;
            end else if (strap_lo_s) begin
               d.mode = DSCP_MODE_TWO;
            end else begin
               d.mode = DSCP_MODE_PAR;
            end
         end else begin
            d.boot_cnt = 2'(q.boot_cnt + 2'h1);
         end
      end

      // Three-wire receiver
      if (!spi_on || sel_s) begin
         d.s_cnt = '0;
         d.s_first = 1'b0;
         d.s_pend = 1'b0;
         d.s_bad = 1'b0;
         if (spi_on && sel_rise && q.s_pend && in_map(q.s_idx)) begin
            do_wr = 1'b1;
            wi = q.s_idx;
            wd = q.s_dat;
         end
      end else if (sclk_rise) begin
         d.s_sh = {q.s_sh[14:0], din_s};
         d.s_cnt = 5'(q.s_cnt + 5'h01);
         if (!q.s_first && d.s_cnt == DSCP_SPI_WORD_BITS) begin
            d.s_first = 1'b1;
            d.s_cnt = '0;
            d.s_bad = q.s_sh[14];
            d.s_idx = q.s_sh[13:7];
            d.s_dat = {q.s_sh[6:0], din_s};
            d.s_pend = !q.s_sh[14];
         end else if (q.s_first && d.s_cnt == DSCP_SPI_BYTE_BITS) begin
            // Each further byte commits the one before it
            d.s_cnt = '0;
            if (q.s_pend && in_map(q.s_idx)) begin
               do_wr = 1'b1;
               wi = q.s_idx;
               wd = q.s_dat;
            end
            d.s_idx = advance(q.s_idx);
            d.s_dat = {q.s_sh[6:0], din_s};
            d.s_pend = !q.s_bad;
         end
      end

      // Two-wire target
      if (!i2c_on || i2c_stop) begin
         d.st = DSCP_ST_IDLE;
         d.oe = 1'b0;
      end else if (i2c_start) begin
         d.st = DSCP_ST_ADDR;
         d.cnt = '0;
         d.oe = 1'b0;
      end else if (scl_rise) begin
         unique case (q.st)
            DSCP_ST_ADDR, DSCP_ST_INDEX, DSCP_ST_WDATA: begin
               d.sh = {q.sh[6:0], sda_s};
               d.cnt = 4'(q.cnt + 4'h1);
            end
            DSCP_ST_RDATA: begin
               d.cnt = 4'(q.cnt + 4'h1);
            end
            DSCP_ST_RACK: begin
               if (sda_s) begin
                  d.st = DSCP_ST_IDLE;
               end else begin
                  d.idx = advance(q.idx);
                  d.sh = q.regs[4'(advance(q.idx) - DSCP_IDX_LO)];
                  d.st = DSCP_ST_ACK;
                  d.nxt = DSCP_ST_RDATA;
               end
            end
            DSCP_ST_IDLE, DSCP_ST_ACK: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (q.st)
            DSCP_ST_ADDR: begin
               if (q.cnt == DSCP_I2C_BYTE_BITS) begin
                  if (addr_match && (!q.sh[0] || in_map(q.idx))) begin
                     d.oe = 1'b1;
                     d.st = DSCP_ST_ACK;
                     d.nxt = q.sh[0] ? DSCP_ST_RDATA : DSCP_ST_INDEX;
                     d.sh = q.regs[4'(q.idx - DSCP_IDX_LO)];
                  end else begin
                     d.st = DSCP_ST_IDLE;
                  end
               end
            end
            DSCP_ST_INDEX: begin
               if (q.cnt == DSCP_I2C_BYTE_BITS) begin
                  if (!q.sh[7] && in_map(q.sh[6:0])) begin
                     d.idx = q.sh[6:0];
                     d.oe = 1'b1;
                     d.st = DSCP_ST_ACK;
                     d.nxt = DSCP_ST_WDATA;
                  end else begin
                     d.st = DSCP_ST_IDLE;
                  end
               end
            end
            DSCP_ST_WDATA: begin
               if (q.cnt == DSCP_I2C_BYTE_BITS) begin
                  if (in_map(q.idx)) begin
                     do_wr = 1'b1;
                     wi = q.idx;
                     wd = q.sh;
                     d.idx = advance(q.idx);
                     d.oe = 1'b1;
                     d.st = DSCP_ST_ACK;
                     d.nxt = DSCP_ST_WDATA;
                  end else begin
                     d.st = DSCP_ST_IDLE;
                  end
               end
            end
            DSCP_ST_ACK: begin
               d.cnt = '0;
               d.st = q.nxt;
               d.oe = (q.nxt == DSCP_ST_RDATA) ? !q.sh[7] : 1'b0;
            end
            DSCP_ST_RDATA: begin
               if (q.cnt == DSCP_I2C_BYTE_BITS) begin
                  d.oe = 1'b0;
                  d.st = DSCP_ST_RACK;
               end else begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.oe = !q.sh[6];
               end
            end
            DSCP_ST_IDLE, DSCP_ST_RACK: begin
            end
         endcase
      end

      if (do_wr) begin
         d.regs[4'(wi - DSCP_IDX_LO)] = wd;
         d.wr_stb = 1'b1;
         d.wr_idx = wi;
         d.wr_dat = wd;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Open drain: the pin is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = q.oe;
   assign cfg_wr_stb = q.wr_stb;
   assign cfg_wr_index = q.wr_idx;
   assign cfg_wr_data = q.wr_dat;
   assign mode_valid = q.booted;
   assign mode_two_wire = q.booted && (q.mode == DSCP_MODE_TWO);
   assign mode_three_wire = q.booted && (q.mode == DSCP_MODE_THREE);
   assign mode_parallel = q.booted && (q.mode == DSCP_MODE_PAR);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_spi_latch;
      spi_on && sel_rise && q.s_pend && in_map(q.s_idx)
         |=> cfg_wr_stb && cfg_wr_index == $past(q.s_idx);
   endproperty
   a_spi_latch: assert property (p_spi_latch)
      else $error("three-wire byte not latched on select release");

   property p_spi_read_bit;
      spi_on && !sel_s && sclk_rise && !q.s_first && q.s_cnt == 5'h0f
         && q.s_sh[14] |=> !q.s_pend ##1 !cfg_wr_stb;
   endproperty
   a_spi_read_bit: assert property (p_spi_read_bit)
      else $error("three-wire word with leading one accepted");

   property p_spi_idle;
      sel_s |=> q.s_cnt == 5'h00 && !q.s_first;
   endproperty
   a_spi_idle: assert property (p_spi_idle)
      else $error("three-wire shifter moved while deselected");

   property p_spi_multi;
      spi_on && !sel_s && sclk_rise && q.s_first && q.s_cnt == 5'h07
         && q.s_pend && in_map(q.s_idx)
         |=> cfg_wr_stb && q.s_idx == advance($past(q.s_idx));
   endproperty
   a_spi_multi: assert property (p_spi_multi)
      else $error("three-wire follow-on byte not written");

   property p_addr_miss;
      i2c_on && !i2c_start && !i2c_stop && scl_fall && q.st == DSCP_ST_ADDR
         && q.cnt == 4'h8 && !addr_match |=> !sda_oe [*2];
   endproperty
   a_addr_miss: assert property (p_addr_miss)
      else $error("acknowledged a foreign address");

   property p_index_undef;
      i2c_on && !i2c_start && !i2c_stop && scl_fall
         && q.st == DSCP_ST_INDEX && q.cnt == 4'h8
         && !in_map(q.sh[6:0]) |=> !sda_oe && q.st == DSCP_ST_IDLE;
   endproperty
   a_index_undef: assert property (p_index_undef)
      else $error("acknowledged an undefined index");

   property p_index_ack;
      i2c_on && !i2c_start && !i2c_stop && scl_fall
         && q.st == DSCP_ST_INDEX && q.cnt == 4'h8 && !q.sh[7]
         && in_map(q.sh[6:0]) |=> sda_oe && q.st == DSCP_ST_ACK;
   endproperty
   a_index_ack: assert property (p_index_ack)
      else $error("valid index not acknowledged low");

   property p_wrap;
      cfg_wr_stb && mode_two_wire && $past(q.idx) == DSCP_IDX_HI
         |-> q.idx == DSCP_IDX_LO;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("index did not wrap to bottom of map");

   property p_incr;
      cfg_wr_stb && mode_two_wire && $past(q.idx) != DSCP_IDX_HI
         |-> q.idx == 7'($past(q.idx) + 7'h01);
   endproperty
   a_incr: assert property (p_incr)
      else $error("index did not advance after data byte");

   property p_release;
      i2c_on && !i2c_start && !i2c_stop && scl_rise
         && q.st == DSCP_ST_RACK && sda_s |=> !sda_oe [*3];
   endproperty
   a_release: assert property (p_release)
      else $error("data line held after master not-acknowledge");

   property p_mode_hold;
      q.booted |=> $stable(q.mode) && q.booted;
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed after strap sampling");

   property p_mode_three;
      !q.booted && q.boot_cnt == DSCP_BOOT_WAIT && strap_hi_s
         |=> mode_three_wire && !mode_two_wire;
   endproperty
   a_mode_three: assert property (p_mode_three)
      else $error("high strap did not select three-wire port");

   c_spi_write: cover property (spi_on && sel_rise && q.s_pend);
   c_spi_multi: cover property (cfg_wr_stb && spi_on && !sel_s);
   c_i2c_write: cover property (cfg_wr_stb && mode_two_wire);
   c_i2c_read: cover property (q.st == DSCP_ST_RACK && scl_rise);

endmodule

// [bench/dscp_host.sv]
// Behavioural host: three-wire writer and two-wire bus master.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module dscp_host (
   // Clock
   input wire logic clock,
   // Three-wire pins
   output logic ctrl_serial_din,
   output logic ctrl_shift_clock,
   output logic ctrl_port_select_n,
   // Two-wire pins
   output logic scl_in,
   output logic sda_pull_low,
   input wire logic sda_line
);
   initial begin
      ctrl_serial_din = 1'b0;
      ctrl_shift_clock = 1'b0;
      ctrl_port_select_n = 1'b1;
      scl_in = 1'b1;
      sda_pull_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // ----------------------------------------------------------------
   // Three-wire frames
   // ----------------------------------------------------------------
   // Shift clock rests low between frames; data-in flips afterwards so
   // a stale bit cannot pass for a real one
   task automatic spi_send(input logic [31:0] bits, input int n);
      ctrl_port_select_n <= 1'b0;
      tick(4);
      for (int i = 31; i > 31 - n; i--) begin
         ctrl_serial_din <= bits[i];
         tick(4);
         ctrl_shift_clock <= 1'b1;
         tick(4);
         ctrl_shift_clock <= 1'b0;
      end
      tick(4);
      ctrl_port_select_n <= 1'b1;
      ctrl_serial_din <= ~bits[32 - n];
      tick(6);
   endtask

   // ----------------------------------------------------------------
   // Two-wire bus
   // ----------------------------------------------------------------
   // Also serves as repeated start; data moves a cycle after the clock
   // falls, so the target never sees a false start or stop
   task automatic i2c_start();
      tick(1);
      sda_pull_low <= 1'b0;
      tick(4);
      scl_in <= 1'b1;
      tick(4);
      sda_pull_low <= 1'b1;
      tick(4);
      scl_in <= 1'b0;
   endtask

   task automatic i2c_bit(input logic b, output logic got);
      tick(1);
      sda_pull_low <= ~b;
      tick(3);
      scl_in <= 1'b1;
      tick(2);
      got = sda_line;
      tick(2);
      scl_in <= 1'b0;
   endtask

   // Send 0xff to read; ack_in high is a not-acknowledge
   task automatic i2c_byte(input logic [7:0] b, input logic ack_in,
                           output logic [7:0] rd, output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(b[i], rd[i]);
      end
      i2c_bit(ack_in, ack_out);
   endtask

   task automatic i2c_stop();
      tick(1);
      sda_pull_low <= 1'b1;
      tick(3);
      scl_in <= 1'b1;
      tick(4);
      sda_pull_low <= 1'b0;
      tick(6);
   endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the serial control port top level.
// Assumes the host model dscp_host and a pulled-up data wire.
`timescale 1ns/1ps
module testbench
   import dscp_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_W = {DSCP_ADDR_UPPER, 2'b01, 1'b0};
   localparam logic [7:0] ADDR_R = {DSCP_ADDR_UPPER, 2'b01, 1'b1};
   logic clock, rst_n, strap_hi, strap_lo, addr_lo, addr_hi;
   logic din, sclk, sel_n, scl, pull_low, sda_out, sda_oe, wr_stb;
   logic m_valid, m_two, m_three, m_par;
   logic [6:0] wr_index;
   logic [7:0] wr_data;
   logic [14:0] wq[$];
   int n_errors = 0;
   int comparisons = 0;
   wire sda_wire = ~((sda_oe & ~sda_out) | pull_low);

   dscp_top dscp_top_i (
      .clock(clock), .rst_n(rst_n), .mode_strap_hi(strap_hi),
      .mode_strap_lo(strap_lo), .ctrl_serial_din(din),
      .ctrl_shift_clock(sclk), .ctrl_port_select_n(sel_n),
      .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .bus_addr_strap_lo(addr_lo),
      .bus_addr_strap_hi(addr_hi), .cfg_wr_stb(wr_stb),
      .cfg_wr_index(wr_index), .cfg_wr_data(wr_data),
      .mode_valid(m_valid), .mode_two_wire(m_two),
      .mode_three_wire(m_three), .mode_parallel(m_par)
   );
   dscp_host dscp_host_i (
      .clock(clock), .ctrl_serial_din(din), .ctrl_shift_clock(sclk),
      .ctrl_port_select_n(sel_n), .scl_in(scl), .sda_pull_low(pull_low),
      .sda_line(sda_wire)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (wr_stb === 1'b1) wq.push_back({wr_index, wr_data});
   end

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic note(input logic bad, input string what);
      comparisons++;
      if (bad) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string s);
      note(got !== exp, s);
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      note(got !== exp, "read data differs");
   endtask
   task automatic chk_write(input logic [6:0] idx, input logic [7:0] dat);
      logic [14:0] got;
      repeat (12) @(posedge clock);
      got = (wq.size() != 0) ? wq.pop_front() : 'x;
      note(got !== {idx, dat}, "register write differs");
   endtask
   task automatic chk_none();
      repeat (12) @(posedge clock);
      note(wq.size() != 0, "unexpected register write");
      wq.delete();
   endtask
   task automatic tx(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rd;
      logic ack;
      dscp_host_i.i2c_byte(b, 1'b1, rd, ack);
      chk_bit(ack, exp_ack, "acknowledge differs");
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Straps flip after sampling; the mode must not follow them
   task automatic do_reset(input logic hi, input logic lo);
      rst_n <= 1'b0;
      strap_hi <= hi;
      strap_lo <= lo;
      repeat (2) @(posedge clock);
      chk_bit(m_valid, 1'b0, "mode valid in reset");
      rst_n <= 1'b1;
      repeat (8) @(posedge clock);
      strap_hi <= ~hi;
      strap_lo <= ~lo;
      repeat (8) @(posedge clock);
      chk_bit(m_valid, 1'b1, "mode not valid");
      chk_bit(m_two, lo, "two-wire flag");
      chk_bit(m_three, hi, "three-wire flag");
      chk_bit(m_par, ~hi & ~lo, "parallel flag");
   endtask

   task automatic spi_single();
      dscp_host_i.spi_send({1'b0, 7'h41, 8'h8a, 16'h0000}, 16);
      chk_write(7'h41, 8'h8a);
   endtask

   task automatic spi_multi();
      dscp_host_i.spi_send({1'b0, 7'h4f, 8'h11, 8'h22, 8'h83}, 32);
      chk_write(7'h4f, 8'h11);
      chk_write(7'h40, 8'h22);
      chk_write(7'h41, 8'h83);
   endtask

   task automatic spi_refused();
      dscp_host_i.spi_send({1'b1, 7'h42, 8'h77, 16'h0000}, 16);
      dscp_host_i.spi_send({1'b0, 7'h30, 8'h77, 16'h0000}, 16);
      dscp_host_i.spi_send({1'b0, 7'h42, 8'h77, 16'h0000}, 15);
      chk_none();
      dscp_host_i.spi_send({1'b0, 7'h43, 8'h66, 8'h55, 8'h00}, 20);
      chk_write(7'h43, 8'h66);
      chk_none();
   endtask

   task automatic i2c_write_wrap();
      dscp_host_i.i2c_start();
      tx(ADDR_W, 1'b0);
      tx(8'h4e, 1'b0);
      tx(8'ha1, 1'b0);
      tx(8'hb2, 1'b0);
      tx(8'hc3, 1'b0);
      dscp_host_i.i2c_stop();
      chk_write(7'h4e, 8'ha1);
      chk_write(7'h4f, 8'hb2);
      chk_write(7'h40, 8'hc3);
   endtask

   task automatic i2c_foreign();
      dscp_host_i.spi_send({1'b0, 7'h41, 8'h8a, 16'h0000}, 16);
      for (int a = 0; a < 4; a++) begin
         if (a != 1) begin
            dscp_host_i.i2c_start();
            tx({DSCP_ADDR_UPPER, 2'(a), 1'b0}, 1'b1);
            tx(8'h41, 1'b1);
            dscp_host_i.i2c_stop();
         end
      end
      dscp_host_i.i2c_start();
      tx({5'h12, 2'b01, 1'b0}, 1'b1);
      dscp_host_i.i2c_stop();
      chk_none();
      // Swapped straps must move the address with them
      addr_lo <= 1'b0;
      addr_hi <= 1'b1;
      repeat (4) @(posedge clock);
      dscp_host_i.i2c_start();
      tx({DSCP_ADDR_UPPER, 2'b10, 1'b0}, 1'b0);
      tx(8'h41, 1'b0);
      tx(8'h8a, 1'b0);
      dscp_host_i.i2c_stop();
      addr_lo <= 1'b1;
      addr_hi <= 1'b0;
      chk_write(7'h41, 8'h8a);
   endtask

   task automatic i2c_undefined();
      for (int k = 0; k < 2; k++) begin
         dscp_host_i.i2c_start();
         tx(ADDR_W, 1'b0);
         tx((k == 0) ? 8'h3f : 8'h50, 1'b1);
         dscp_host_i.i2c_stop();
      end
      chk_none();
   endtask

   task automatic i2c_read();
      logic [7:0] rd;
      logic ack;
      dscp_host_i.i2c_start();
      tx(ADDR_W, 1'b0);
      tx(8'h4f, 1'b0);
      dscp_host_i.i2c_start();
      tx(ADDR_R, 1'b0);
      dscp_host_i.i2c_byte(8'hff, 1'b0, rd, ack);
      chk_byte(rd, 8'hb2);
      dscp_host_i.i2c_byte(8'hff, 1'b1, rd, ack);
      chk_byte(rd, 8'hc3);
      chk_bit(sda_oe, 1'b0, "data line still held");
      dscp_host_i.i2c_stop();
   endtask

   task automatic parallel_quiet();
      dscp_host_i.spi_send({1'b0, 7'h41, 8'h8a, 16'h0000}, 16);
      dscp_host_i.i2c_start();
      tx(ADDR_W, 1'b1);
      dscp_host_i.i2c_stop();
      chk_none();
   endtask

   // ----------------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      strap_hi = 1'b1;
      strap_lo = 1'b0;
      addr_lo = 1'b1;
      addr_hi = 1'b0;
      do_reset(1'b1, 1'b0);
      spi_single();
      spi_multi();
      spi_refused();
      do_reset(1'b0, 1'b1);
      i2c_write_wrap();
      i2c_foreign();
      i2c_undefined();
      i2c_read();
      do_reset(1'b0, 1'b0);
      parallel_quiet();
      complete_run();
   end

   initial begin
      repeat (30000) @(posedge clock);
      n_errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      complete_run();
   end
endmodule
